// [common/csf_params.svh]
// register offsets, field positions and reset values of the status block
// assumes inclusion by the package and the design file only
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH
`define CSF_OFF_STATUS   4'h0
`define CSF_OFF_CORECTL  4'h4
`define CSF_OFF_INTCTL1  4'h8
`define CSF_OFF_ALUOP    4'hc
`define CSF_BIT_C        0
`define CSF_BIT_Z        1
`define CSF_BIT_OV       2
`define CSF_BIT_N        3
`define CSF_BIT_RA       4
`define CSF_BIT_IPL_LO   5
`define CSF_BIT_IPL_HI   7
`define CSF_BIT_SAB      9
`define CSF_BIT_SB       10
`define CSF_BIT_SA       11
`define CSF_BIT_IPL3     3
`define CSF_BIT_NESTING_DISABLE   15
`define CSF_IPL_BLOCK    3'h7
`define CSF_RST_STATUS   16'h0000
`define CSF_RST_WORD     32'h0000_0000
`define CSF_UNMAPPED     32'h0000_0000
`endif

// [common/csf_pkg.sv]
// types shared by the status flag register block
// assumes csf_params.svh is on the include path
package csf_pkg;
`include "csf_params.svh"
   typedef enum logic [1:0] {
      CSF_OP_ADD,
      CSF_OP_SUB,
      CSF_OP_LOGIC
   } csf_op_t;

   // one result reported by the execution unit
   typedef struct packed {
      logic        valid;
      csf_op_t     op;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] res;
      logic        affN;
      logic        affOv;
      logic        affZ;
      logic        affC;
   } csf_alu_t;

   typedef struct packed {
      logic        c;
      logic        z;
      logic        ov;
      logic        n;
      logic        ra;
      logic [2:0]  ipl;
      logic        sa;
      logic        sb;
   } csf_flags_t;

   typedef enum logic {
      CSF_IDLE,
      CSF_DONE
   } csf_bus_st_t;
endpackage

// [hdl/csf_status_reg.sv]
// status flag register of the core with an avalon-mm slave port
// assumes one clock; the execution unit drives aluIn and loopActive
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "csf_params.svh"

module csf_status_reg
   import csf_pkg::*;
#(
   parameter int DataW = 16
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [3:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   input  wire logic [3:0]  avsByteenable,
   output logic      [31:0] avsReaddata,
   output logic             avsWaitrequest,
   input  wire csf_alu_t    aluIn,
   input  wire logic        loopActive,
   input  wire logic        clipSetA,
   input  wire logic        clipSetB,
   output logic      [15:0] cpuStatusReg,
   output logic      [3:0]  effPriority,
   output logic             userIntBlocked
);
   typedef struct packed {
      csf_flags_t  f;
      logic [15:0] coreCtl;
      logic [15:0] intCtl1;
      logic [2:0]  lastOp;
      csf_bus_st_t st;
      logic [31:0] rdata;
      logic        wait_;
      logic [15:0] status;
      logic [3:0]  prio;
      logic        blocked;
   } csf_state_t;

   csf_state_t s_r;
   csf_state_t s_nxt;

   function automatic logic [15:0] pack_status(input csf_flags_t f);
      logic [15:0] v;
      v = `CSF_RST_STATUS;
      v[`CSF_BIT_C] = f.c;
      v[`CSF_BIT_Z] = f.z;
      v[`CSF_BIT_OV] = f.ov;
      v[`CSF_BIT_N] = f.n;
      v[`CSF_BIT_RA] = f.ra;
      v[`CSF_BIT_IPL_HI:`CSF_BIT_IPL_LO] = f.ipl;
      v[`CSF_BIT_SA] = f.sa;
      v[`CSF_BIT_SB] = f.sb;
      v[`CSF_BIT_SAB] = f.sa | f.sb;
      return v;
   endfunction

   // byte-lane merge used for all three writable words
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [15:0] v;
      v = old;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction

   // add and subtract drive carry and wrap; logic ops keep the carry and clear the wrap
   function automatic logic op_is_arith(input csf_op_t op);
      logic y;
      case (op)
         CSF_OP_ADD: begin
            y = 1'b1;
         end
         CSF_OP_SUB: begin
            y = 1'b1;
         end
         default: begin
            y = 1'b0;
         end
      endcase
      return y;
   endfunction

   // carry out of the msb; a subtract reports no borrow as carry set
   function automatic logic carry_of(input csf_op_t     op,
                                     input logic [15:0] a,
                                     input logic [15:0] b);
      logic [16:0] sum;
      logic [16:0] dif;
      logic        c;
      sum = {1'b0, a} + {1'b0, b};
      dif = {1'b0, a} - {1'b0, b};
      if (op == CSF_OP_SUB) begin
         c = ~dif[DataW];
      end else begin
         c = sum[DataW];
      end
      return c;
   endfunction

   // signed wrap: the result sign left that of the first operand while
   // the operand signs agreed (add) or differed (subtract)
   function automatic logic wrap_of(input csf_op_t     op,
                                    input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic [15:0] r);
      logic sameSign;
      logic signMoved;
      logic w;
      sameSign = (a[DataW-1] == b[DataW-1]);
      signMoved = (r[DataW-1] != a[DataW-1]);
      case (op)
         CSF_OP_ADD: begin
            w = sameSign && signMoved;
         end
         CSF_OP_SUB: begin
            w = !sameSign && signMoved;
         end
         default: begin
            w = 1'b0;
         end
      endcase
      return w;
   endfunction

   // unmapped addresses read as zero and the upper half is always zero
   function automatic logic [31:0] read_word(input logic [3:0]  addr,
                                             input logic [15:0] st,
                                             input logic [15:0] core,
                                             input logic [15:0] ictl,
                                             input logic [2:0]  op);
      logic [31:0] v;
      case (addr)
         `CSF_OFF_STATUS: begin
            v = {16'h0000, st};
         end
         `CSF_OFF_CORECTL: begin
            v = {16'h0000, core};
         end
         `CSF_OFF_INTCTL1: begin
            v = {16'h0000, ictl};
         end
         `CSF_OFF_ALUOP: begin
            v = {29'h0, op};
         end
         default: begin
            v = `CSF_UNMAPPED;
         end
      endcase
      return v;
   endfunction

   // software write to the status word; clearing the combined clip flag
   // drops both accumulator flags at once
   function automatic csf_flags_t write_status(input csf_flags_t  f,
                                               input logic [15:0] word,
                                               input logic [3:0]  be,
                                               input logic        lock);
      csf_flags_t v;
      logic       dropBoth;
      v = f;
      dropBoth = !word[`CSF_BIT_SAB] && (f.sa || f.sb);
      if (be[0]) begin
         v.c = word[`CSF_BIT_C];
         v.z = word[`CSF_BIT_Z];
         v.ov = word[`CSF_BIT_OV];
         v.n = word[`CSF_BIT_N];
         if (!lock) begin
            v.ipl = word[`CSF_BIT_IPL_HI:`CSF_BIT_IPL_LO];
         end
      end
      if (be[1]) begin
         if (dropBoth) begin
            v.sa = 1'b0;
            v.sb = 1'b0;
         end else begin
            v.sa = word[`CSF_BIT_SA];
            v.sb = word[`CSF_BIT_SB];
         end
      end
      return v;
   endfunction

   logic        wrHit;
   logic        rdHit;
   logic [15:0] wv;
   logic [15:0] stNow;

   always_comb begin
      s_nxt = s_r;
      wrHit = 1'b0;
      rdHit = 1'b0;
      wv = 16'h0000;
      stNow = pack_status(s_r.f);

      s_nxt.f.ra = loopActive;
      // arithmetic flags change only when the op affects them
      if (aluIn.valid) begin
         if (aluIn.affN) begin
            s_nxt.f.n = aluIn.res[DataW-1];
         end
         if (aluIn.affZ) begin
            s_nxt.f.z = (aluIn.res == 16'h0000);
         end
         // logic ops keep the carry; wrap_of clears the wrap flag for them
         if (aluIn.affC && op_is_arith(aluIn.op)) begin
            s_nxt.f.c = carry_of(aluIn.op, aluIn.a, aluIn.b);
         end
         if (aluIn.affOv) begin
            s_nxt.f.ov = wrap_of(aluIn.op, aluIn.a, aluIn.b,
                                 aluIn.res);
         end
      end

      // bus: one wait cycle; read data is latched at the edge that first sees the request,
      // a write lands at the edge where the master sees waitrequest low
      case (s_r.st)
         CSF_IDLE: begin
            s_nxt.wait_ = 1'b1;
            if (avsRead || avsWrite) begin
               s_nxt.st = CSF_DONE;
               s_nxt.wait_ = 1'b0;
               rdHit = avsRead;
            end
         end
         CSF_DONE: begin
            s_nxt.st = CSF_IDLE;
            s_nxt.wait_ = 1'b1;
            wrHit = avsWrite;
         end
         default: begin
            s_nxt.st = CSF_IDLE;
            s_nxt.wait_ = 1'b1;
         end
      endcase

      if (rdHit) begin
         s_nxt.rdata = read_word(avsAddress, stNow, s_r.coreCtl,
                                 s_r.intCtl1, s_r.lastOp);
      end

      // a software write lands after the alu and loop updates of this cycle
      if (wrHit) begin
         case (avsAddress)
            `CSF_OFF_STATUS: begin
               wv = merge16(stNow, avsWritedata, avsByteenable);
               s_nxt.f = write_status(s_nxt.f, wv, avsByteenable,
                                      s_r.intCtl1[`CSF_BIT_NESTING_DISABLE]);
            end
            `CSF_OFF_CORECTL: begin
               s_nxt.coreCtl = merge16(s_r.coreCtl, avsWritedata,
                                       avsByteenable);
            end
            `CSF_OFF_INTCTL1: begin
               s_nxt.intCtl1 = merge16(s_r.intCtl1, avsWritedata,
                                       avsByteenable);
            end
            default: begin
               s_nxt.lastOp = s_r.lastOp;
            end
         endcase
      end

      // hardware saturation events win over a clearing write
      if (clipSetA) begin
         s_nxt.f.sa = 1'b1;
      end
      if (clipSetB) begin
         s_nxt.f.sb = 1'b1;
      end
      if (aluIn.valid) begin
         s_nxt.lastOp = {1'b1, aluIn.op};
      end

      s_nxt.status = pack_status(s_nxt.f);
      s_nxt.prio = {s_nxt.coreCtl[`CSF_BIT_IPL3], s_nxt.f.ipl};
      s_nxt.blocked = (s_nxt.f.ipl == `CSF_IPL_BLOCK);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r <= '0;
         s_r.wait_ <= 1'b1;
         s_r.st <= CSF_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avsReaddata = s_r.rdata;
   assign avsWaitrequest = s_r.wait_;
   assign cpuStatusReg = s_r.status;
   assign effPriority = s_r.prio;
   assign userIntBlocked = s_r.blocked;
endmodule

// [tb/csf_exec_model.sv]
// stand-in for the execution unit: one result per call, loop level
// assumes the bench calls issue and loop from its own thread
`timescale 1ns/1ps
module csf_exec_model
   import csf_pkg::*;
(
   input  wire logic mclk,
   output csf_alu_t  aluIn,
   output logic      loopActive
);
   initial begin
      aluIn = '0;
      loopActive = 1'b0;
   end
   task automatic issue(input csf_op_t o, input logic [15:0] a,
                        input logic [15:0] b, input logic [3:0] f);
      logic [15:0] r;
      r = (o == CSF_OP_ADD) ? a + b : (o == CSF_OP_SUB) ? a - b : a & b;
      @(posedge mclk);
      aluIn <= {1'b1, o, a, b, r, f};
      @(posedge mclk);
      // stale operands must not look valid, so invert them
      aluIn <= {1'b0, o, ~a, ~b, ~r, f};
   endtask
   task automatic loop(input logic v);
      @(posedge mclk);
      loopActive <= v;
   endtask
endmodule

// [tb/csf_status_reg_checker.sv]
// port assertions for the status flag register
// assumes it is bound into every csf_status_reg
`timescale 1ns/1ps
module csf_status_reg_checker
   import csf_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic        avsWaitrequest,
   input wire csf_alu_t    aluIn,
   input wire logic        loopActive,
   input wire logic [15:0] cpuStatusReg,
   input wire logic        userIntBlocked
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [16:0] sum;
   logic        upd;
   assign sum = {1'b0, aluIn.a} + {1'b0, aluIn.b};
   // a taken status write wins over the alu, so leave those edges out
   assign upd = aluIn.valid && !avsWrite;
   a_loop_copy: assert property (!$past(rst) |->
      cpuStatusReg[4] == $past(loopActive)) else $error("loop bit wrong");
   a_neg_sign: assert property (upd && aluIn.affN |=>
      cpuStatusReg[3] == $past(aluIn.res[15])) else $error("n bit wrong");
   a_zero_res: assert property (upd && aluIn.affZ |=>
      cpuStatusReg[1] == ($past(aluIn.res) == 16'h0000))
      else $error("z bit wrong");
   a_flag_hold: assert property (!aluIn.valid && !avsWrite |=>
      $stable(cpuStatusReg[3:0])) else $error("flags moved");
   a_carry_add: assert property (upd && aluIn.affC &&
      aluIn.op == CSF_OP_ADD |=> cpuStatusReg[0] == $past(sum[16]))
      else $error("carry wrong");
   a_top_block: assert property (cpuStatusReg[7:5] == 3'h7 |->
      ##[0:1] userIntBlocked) else $error("not blocked");
   a_bus_answer: assert property ($rose(avsRead || avsWrite) |=>
      !avsWaitrequest) else $error("late answer");
   a_wait_once: assert property (!avsWaitrequest |=>
      avsWaitrequest) else $error("waitrequest low too long");
   c_zero: cover property (upd && aluIn.affZ);
   c_block: cover property (userIntBlocked);
   c_write: cover property ($rose(avsWrite));
endmodule
bind csf_status_reg csf_status_reg_checker chk_u (.*);

// [tb/csf_status_reg_tb.sv]
// self-checking bench for the status flag register
// assumes the design, its checker and the execution model
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module csf_status_reg_tb import csf_pkg::*;;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avsAddress = 4'h0;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0000_0000;
   logic [3:0]  avsByteenable = 4'h3;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   csf_alu_t    aluIn;
   logic        loopActive;
   logic        clipSetA = 1'b0;
   logic        clipSetB = 1'b0;
   logic [15:0] cpuStatusReg;
   logic [3:0]  effPriority;
   logic        userIntBlocked;
   logic [31:0] q;
   int          bad_count = 0;
   int          tests_run = 0;
   csf_op_t     tOp [7] = '{CSF_OP_ADD, CSF_OP_ADD, CSF_OP_ADD,
      CSF_OP_SUB, CSF_OP_SUB, CSF_OP_SUB, CSF_OP_LOGIC};
   logic [15:0] tA  [7] = '{16'h7fff, 16'hffff, 16'h0001, 16'h0005,
      16'h0000, 16'h8000, 16'h00f0};
   logic [15:0] tB  [7] = '{16'h0001, 16'h0001, 16'h0001, 16'h0005,
      16'h0001, 16'h0001, 16'h0f00};
   logic [3:0]  tF  [7] = '{4'hf, 4'hf, 4'h0, 4'hf, 4'hf, 4'hf, 4'he};
   logic [3:0]  tE  [7] = '{4'hc, 4'h3, 4'h3, 4'h3, 4'h8, 4'h5, 4'h3};
   always #50 mclk = ~mclk;
   csf_status_reg dut_u (.*);
   csf_exec_model xu (.*);
   task automatic summarize();
      if (bad_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] ad,
                      input logic [15:0] d);
      int n;
      @(posedge mclk);
      avsAddress   <= ad;
      avsWrite     <= w;
      avsRead      <= ~w;
      avsWritedata <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      q = avsReaddata;
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         summarize();
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 16'h0000);
      `CHK(q, 32'h0000_0000)
      bus(1'b0, 4'h2, 16'h0000);
      `CHK(q, 32'h0000_0000)
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, 4'h4, {12'h000, i[3], 3'h0});
         bus(1'b1, 4'h0, {8'h00, i[2:0], 5'h00});
         @(posedge mclk);
         `CHK(effPriority, i[3:0])
         `CHK(userIntBlocked, i[2:0] == 3'h7)
      end
      bus(1'b0, 4'h4, 16'h0000);
      `CHK(q, 32'h0000_0008)
      bus(1'b1, 4'h8, 16'h8000);
      bus(1'b1, 4'h0, 16'h0040);
      bus(1'b0, 4'h0, 16'h0000);
      `CHK(q[7:5], 3'h7)
      bus(1'b1, 4'h8, 16'h0000);
      bus(1'b1, 4'h0, 16'h0000);
      xu.loop(1'b1);
      repeat (2) @(posedge mclk);
      `CHK(cpuStatusReg[4], 1'b1)
      xu.loop(1'b0);
      repeat (2) @(posedge mclk);
      `CHK(cpuStatusReg[4], 1'b0)
      for (int k = 0; k < 7; k++) begin
         xu.issue(tOp[k], tA[k], tB[k], tF[k]);
         @(posedge mclk);
         `CHK(cpuStatusReg[3:0], tE[k])
      end
      clipSetA <= 1'b1;
      clipSetB <= 1'b1;
      @(posedge mclk);
      clipSetA <= 1'b0;
      clipSetB <= 1'b0;
      bus(1'b0, 4'h0, 16'h0000);
      `CHK(q[11:9], 3'h7)
      bus(1'b1, 4'h0, 16'h0a00);
      bus(1'b0, 4'h0, 16'h0000);
      `CHK(q[11:9], 3'h5)
      bus(1'b1, 4'h0, 16'h0000);
      bus(1'b0, 4'h0, 16'h0000);
      `CHK(q[11:9], 3'h0)
      summarize();
   end
endmodule
